// ==== design/trsup_top.sv ====
// Trip path supervision block: watches breaker auxiliary contacts and
// raises a delayed alarm when the trip path is broken or unpowered.
// Assumes a 100 MHz clock, pins asynchronous, registers on a plain port.
//
// Summary of operation
// - Enable setting, default off; when off nothing is monitored or alarmed.
// - Block permit acts only if a blocking input is assigned.
// - Assigned blocking input true with permit on blocks and kills alarm.
// - Alarm delay settable 0.10 to 10.00 s, default 0.2 s.
// - Normally-open and normally-closed contact inputs are accepted and reported.
// - Two external blocking inputs are accepted and reported.
// - Selected breaker position source is accepted and reported.
// - Outputs active, externally blocked and alarm indications.
// - Not-possible shown while no breaker position source is assigned.
// - Lost control voltage raises the alarm after the delay.
// - Broken control circuit raises the alarm after the delay.
// - One contact: watch only when closed; both: watch always.
// - Mode Closed or Either, default Closed; second input only in Either.
`timescale 1ns/1ps
`default_nettype none
module trsup_top
  import trsup_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              aux_on_i,
  input  wire logic              aux_off_i,
  input  wire logic              ext_block_one_i,
  input  wire logic              ext_block_two_i,
  input  wire logic              breaker_position_source_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   active_o,
  output logic                   ext_blocked_flag_o,
  output logic                   alarm_o,
  output logic                   not_possible_o,
  output logic                   irq_o
);

  // Address match, shared by the write and read decoders.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  // Fault test of the monitored input for the present mode and position.
  // A digital input fed from the trip circuit reads low when the path is
  // broken or its control voltage is gone.
  function automatic logic path_fault(input logic either,
                                      input logic closed,
                                      input logic on_in,
                                      input logic off_in);
    if (closed)
    begin
      path_fault = !on_in;
    end
    else if (either)
    begin
      path_fault = !off_in;
    end
    else
    begin
      path_fault = 1'b0;
    end
  endfunction : path_fault

  logic [PIN_W-1:0]  pins_async;
  logic [PIN_W-1:0]  pins;
  logic              aux_on;
  logic              aux_off;
  logic              blk_one;
  logic              blk_two;
  logic              pos_closed;

  logic [CTRL_W-1:0]  ctrl_reg;
  logic [DELAY_W-1:0] delay_reg;
  logic [DELAY_W-1:0] delay_next;
  logic [EV_W-1:0]    irq_status_reg;
  logic [EV_W-1:0]    irq_enable_reg;
  logic [DATA_W-1:0]  rdata_reg;
  logic [DATA_W-1:0]  rdata_next;

  logic              enable;
  logic              permit;
  logic              either;
  logic              blocked;
  logic              not_possible;
  logic              fault;
  logic              alarm;
  logic [EV_W-1:0]   events;
  logic [EV_W-1:0]   clr_mask;
  logic              alarm_prev_reg;
  logic              blocked_prev_reg;
  logic              notposs_prev_reg;
  logic [DATA_W-1:0] state_word;

  trsup_timer_if tmr_if ();

  // Pins cross into the clock domain through two flip-flops each.
  assign pins_async = {breaker_position_source_i, ext_block_two_i,
                       ext_block_one_i, aux_off_i, aux_on_i};

  trsup_sync #(
    .WIDTH   (PIN_W)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (pins_async),
    .sync_o  (pins)
  );

  // Synchronised input states.
  assign aux_on     = pins[0];
  assign aux_off    = pins[1];
  assign blk_one    = pins[2];
  assign blk_two    = pins[3];
  assign pos_closed = pins[4];

  // Settings taken from the control register.
  assign enable = ctrl_reg[CTRL_ENABLE_BIT];
  assign permit = ctrl_reg[CTRL_PERMIT_BIT];
  assign either = ctrl_reg[CTRL_EITHER_BIT];

  // Blocking needs the permit and a blocking input that is both
  // assigned and true; an unassigned input never blocks.
  assign blocked = enable && permit &&
                   ((ctrl_reg[CTRL_BLK1_AS_BIT] && blk_one) ||
                    (ctrl_reg[CTRL_BLK2_AS_BIT] && blk_two));

  // Without a position source there is no way to tell which contact
  // to watch, so supervision is reported as impossible.
  assign not_possible = enable && !ctrl_reg[CTRL_POS_AS_BIT];

  // Closed mode watches the 52a input only with the breaker closed;
  // Either mode also watches the 52b input with the breaker open.
  assign fault = path_fault(either, pos_closed, aux_on, aux_off);

  // The delay runs only while supervision is live and a fault is seen.
  assign tmr_if.run   = enable && !blocked && !not_possible && fault;
  assign tmr_if.limit = delay_reg;

  trsup_timer #(
    .TICKS   (TICKS)
  ) u_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tmr     (tmr_if.timer)
  );

  // Alarm once the delay expires; it falls as soon as run drops.
  assign alarm = tmr_if.expired;

  // Delay write value clamped into the legal range.
  always_comb
  begin
    if (wdata_i[DELAY_W-1:0] < DELAY_MIN)
    begin
      delay_next = DELAY_MIN;
    end
    else if (wdata_i[DELAY_W-1:0] > DELAY_MAX)
    begin
      delay_next = DELAY_MAX;
    end
    else
    begin
      delay_next = wdata_i[DELAY_W-1:0];
    end
  end

  // Control register: enable, permit, mode and assignment flags.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (wr_i && hit(addr_i, CTRL_ADDR))
    begin
      ctrl_reg <= wdata_i[CTRL_W-1:0];
    end
  end

  // Alarm delay register in 10 ms units.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      delay_reg <= DELAY_RESET;
    end
    else if (wr_i && hit(addr_i, DELAY_ADDR))
    begin
      delay_reg <= delay_next;
    end
  end

  // Previous output states for edge events.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      alarm_prev_reg   <= 1'b0;
      blocked_prev_reg <= 1'b0;
      notposs_prev_reg <= 1'b0;
    end
    else
    begin
      alarm_prev_reg   <= alarm;
      blocked_prev_reg <= blocked;
      notposs_prev_reg <= not_possible;
    end
  end

  // Events: alarm raised, alarm cleared, blocked, not possible.
  assign events[EV_ALARM_SET] = alarm && !alarm_prev_reg;
  assign events[EV_ALARM_CLR] = !alarm && alarm_prev_reg;
  assign events[EV_BLOCKED]   = blocked && !blocked_prev_reg;
  assign events[EV_NOTPOSS]   = not_possible && !notposs_prev_reg;

  // Bits written with one in the clear register.
  assign clr_mask = (wr_i && hit(addr_i, IRQ_CLEAR_ADDR)) ?
                    wdata_i[EV_W-1:0] : '0;

  // Sticky status: an event in the clearing cycle still sets its bit.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_status_reg <= '0;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~clr_mask) | events;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_enable_reg <= '0;
    end
    else if (wr_i && hit(addr_i, IRQ_ENABLE_ADDR))
    begin
      irq_enable_reg <= wdata_i[EV_W-1:0];
    end
  end

  // Live state word: input states then output states.
  always_comb
  begin
    state_word                 = '0;
    state_word[ST_AUX_ON_BIT]  = aux_on;
    state_word[ST_AUX_OFF_BIT] = aux_off;
    state_word[ST_BLK1_BIT]    = blk_one;
    state_word[ST_BLK2_BIT]    = blk_two;
    state_word[ST_POS_BIT]     = pos_closed;
    state_word[ST_ACTIVE_BIT]  = enable;
    state_word[ST_BLOCKED_BIT] = blocked;
    state_word[ST_ALARM_BIT]   = alarm;
    state_word[ST_NOTPOSS_BIT] = not_possible;
  end

  // Read multiplexer; unmapped and write-only addresses read zero.
  always_comb
  begin
    rdata_next = '0;
    if (hit(addr_i, CTRL_ADDR))
    begin
      rdata_next[CTRL_W-1:0] = ctrl_reg;
    end
    else if (hit(addr_i, DELAY_ADDR))
    begin
      rdata_next[DELAY_W-1:0] = delay_reg;
    end
    else if (hit(addr_i, STATE_ADDR))
    begin
      rdata_next = state_word;
    end
    else if (hit(addr_i, IRQ_STATUS_ADDR))
    begin
      rdata_next[EV_W-1:0] = irq_status_reg;
    end
    else if (hit(addr_i, IRQ_ENABLE_ADDR))
    begin
      rdata_next[EV_W-1:0] = irq_enable_reg;
    end
    else
    begin
      rdata_next = '0;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_reg <= '0;
    end
    else if (rd_i)
    begin
      rdata_reg <= rdata_next;
    end
    else
    begin
      rdata_reg <= '0;
    end
  end

  // Output states.
  assign rdata_o            = rdata_reg;
  assign active_o           = enable;
  assign ext_blocked_flag_o = blocked;
  assign alarm_o            = alarm;
  assign not_possible_o     = not_possible;
  assign irq_o              = |(irq_status_reg & irq_enable_reg);

endmodule : trsup_top
`default_nettype wire

// ==== common/trsup_pkg.sv ====
// Package for the trip path supervision block: register map, fields,
// reset values and timing constants.
// Assumes a 100 MHz system clock and a word-indexed register port.
package trsup_pkg;

  // Register width and address width of the register port.
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  // Register indices on the register port.
  localparam logic [3:0] CTRL_ADDR       = 4'h0;
  localparam logic [3:0] DELAY_ADDR      = 4'h1;
  localparam logic [3:0] STATE_ADDR      = 4'h2;
  localparam logic [3:0] IRQ_STATUS_ADDR = 4'h3;
  localparam logic [3:0] IRQ_ENABLE_ADDR = 4'h4;
  localparam logic [3:0] IRQ_CLEAR_ADDR  = 4'h5;

  // Control register fields.
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_PERMIT_BIT  = 1;
  localparam int unsigned CTRL_EITHER_BIT  = 2;
  localparam int unsigned CTRL_BLK1_AS_BIT = 3;
  localparam int unsigned CTRL_BLK2_AS_BIT = 4;
  localparam int unsigned CTRL_POS_AS_BIT  = 5;
  localparam int unsigned CTRL_W           = 6;
  localparam logic [5:0]  CTRL_RESET       = 6'h00;

  // State register fields: synchronised inputs, then output states.
  localparam int unsigned ST_AUX_ON_BIT   = 0;
  localparam int unsigned ST_AUX_OFF_BIT  = 1;
  localparam int unsigned ST_BLK1_BIT     = 2;
  localparam int unsigned ST_BLK2_BIT     = 3;
  localparam int unsigned ST_POS_BIT      = 4;
  localparam int unsigned ST_ACTIVE_BIT   = 5;
  localparam int unsigned ST_BLOCKED_BIT  = 6;
  localparam int unsigned ST_ALARM_BIT    = 7;
  localparam int unsigned ST_NOTPOSS_BIT  = 8;

  // Interrupt event bits.
  localparam int unsigned EV_ALARM_SET    = 0;
  localparam int unsigned EV_ALARM_CLR    = 1;
  localparam int unsigned EV_BLOCKED      = 2;
  localparam int unsigned EV_NOTPOSS      = 3;
  localparam int unsigned EV_W            = 4;

  // Alarm delay in units of 10 ms: 0.10 s to 10.00 s, default 0.2 s.
  localparam int unsigned DELAY_W         = 10;
  localparam logic [9:0]  DELAY_MIN       = 10'h00A;
  localparam logic [9:0]  DELAY_MAX       = 10'h3E8;
  localparam logic [9:0]  DELAY_RESET     = 10'h014;

  // Delay unit and the clock cycles it spans.
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned DELAY_UNIT_NS   = 10_000_000;
  localparam int unsigned TICK_CYCLES     = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // Input pin count of the synchroniser bank.
  localparam int unsigned PIN_W           = 5;

endpackage : trsup_pkg

// ==== common/trsup_timer_if.sv ====
// Interface between the supervision control and its alarm delay timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface trsup_timer_if
  import trsup_pkg::*;
();
  logic               run;
  logic [DELAY_W-1:0] limit;
  logic               expired;
  logic [DELAY_W-1:0] elapsed;

  // The control side starts the timer and reads its result.
  modport ctrl (output run, output limit, input expired, input elapsed);
  // The timer side counts while run is high.
  modport timer (input run, input limit, output expired, output elapsed);
endinterface : trsup_timer_if
`default_nettype wire

// ==== design/trsup_sync.sv ====
// Two-flop synchroniser bank for the supervision input pins.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module trsup_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Each pin passes two flip-flops; only the second is read.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (reset_i)
        begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= async_i[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_reg;
endmodule : trsup_sync
`default_nettype wire

// ==== design/trsup_timer.sv ====
// Alarm delay timer: counts 10 ms units while run is high.
// Assumes run drops for at least one cycle to restart the delay.
`timescale 1ns/1ps
`default_nettype none
module trsup_timer
  import trsup_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES
) (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  trsup_timer_if.timer tmr
);
  logic [31:0]        pre_reg;
  logic               tick;
  logic [DELAY_W-1:0] cnt_reg;

  // Unit prescaler, held at zero while idle so every delay starts clean.
  assign tick = (pre_reg == 32'(TICKS - 1));

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !tmr.run || tick)
    begin
      pre_reg <= 32'h0000_0000;
    end
    else
    begin
      pre_reg <= pre_reg + 32'h0000_0001;
    end
  end

  // Elapsed units; a drop of run restarts the delay.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !tmr.run)
    begin
      cnt_reg <= '0;
    end
    else if (tick && !tmr.expired)
    begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end

  assign tmr.elapsed = cnt_reg;
  assign tmr.expired = tmr.run && (cnt_reg >= tmr.limit);
endmodule : trsup_timer
`default_nettype wire

// ==== sim/trsup_asserts.sv ====
// Checker for the trip path supervision block, watching its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module trsup_asserts
  import trsup_pkg::*;
#(
  parameter int unsigned TICKS = 4
) (
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              aux_on_i,
  input wire logic              aux_off_i,
  input wire logic              ext_block_one_i,
  input wire logic              ext_block_two_i,
  input wire logic              breaker_position_source_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              active_o,
  input wire logic              ext_blocked_flag_o,
  input wire logic              alarm_o,
  input wire logic              not_possible_o,
  input wire logic              irq_o
);
  localparam int MIN_RUN = 10 * TICKS - 2;
  logic [31:0] run_cnt_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Counts cycles in which the delay may run; the shortest delay needs many.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !active_o || ext_blocked_flag_o || not_possible_o)
      run_cnt_reg <= '0;
    else
      run_cnt_reg <= run_cnt_reg + 32'h1;
  end

  // A closed breaker with a live contact for three samples is healthy.
  sequence healthy_s;
    (aux_on_i && breaker_position_source_i) [*3];
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) $fell(reset_i) |-> !active_o && !alarm_o && !irq_o)
    else $error("outputs not quiet after reset");
  alarm_gate_a: assert property (alarm_o |-> active_o && !not_possible_o)
    else $error("alarm while inactive or not possible");
  np_active_a: assert property (not_possible_o |-> active_o)
    else $error("not possible while inactive");
  block_clears_a: assert property ($rose(ext_blocked_flag_o) |-> !alarm_o)
    else $error("alarm kept while blocked");
  alarm_delay_a: assert property ($rose(alarm_o) |-> run_cnt_reg >= MIN_RUN)
    else $error("alarm before shortest delay");
  healthy_quiet_a: assert property (healthy_s |=> !alarm_o)
    else $error("alarm with healthy trip path");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (rd_i && addr_i > IRQ_ENABLE_ADDR |=> rdata_o == '0)
    else $error("unmapped read not zero");
  irq_mask_a: assert property (wr_i && addr_i == IRQ_ENABLE_ADDR && wdata_i == '0 |=> !irq_o)
    else $error("interrupt with all sources masked");
endmodule : trsup_asserts
`default_nettype wire

// ==== sim/trsup_breaker_model.sv ====
// Behavioural breaker whose auxiliary contacts are looped into the trip circuit.
// Assumes contact levels reach the block as plain logic levels.
`timescale 1ns/1ps
`default_nettype none
module trsup_breaker_model (
  input  wire logic closed_i,
  input  wire logic supply_ok_i,
  input  wire logic wire_ok_i,
  output logic      aux_on_o,
  output logic      aux_off_o,
  output logic      position_o
);
  // A contact input sees the trip supply only through an intact loop.
  assign aux_on_o   = closed_i & supply_ok_i & wire_ok_i;
  assign aux_off_o  = ~closed_i & supply_ok_i & wire_ok_i;
  assign position_o = closed_i;
endmodule : trsup_breaker_model
`default_nettype wire

// ==== sim/trsup_top_test.sv ====
// Self-checking bench for the supervision block with a breaker model.
// Assumes TICKS is shortened to 4 so one delay unit is 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module trsup_top_test
  import trsup_pkg::*;
;
  localparam int unsigned TICKS = 4;
  logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic bk_closed = 1'b1, supply_ok = 1'b1, wire_ok = 1'b1, blk1 = 1'b0, blk2 = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  wire logic [DATA_W-1:0] rdata_o;
  wire logic aux_on, aux_off, pos, active_o, ext_blocked_flag_o, alarm_o, not_possible_o, irq_o;
  int fail_count = 0, samples_checked = 0, cycles = 0;

  trsup_breaker_model trsup_breaker_model_inst (.closed_i(bk_closed), .supply_ok_i(supply_ok),
    .wire_ok_i(wire_ok), .aux_on_o(aux_on), .aux_off_o(aux_off), .position_o(pos));
  trsup_top #(.TICKS(TICKS)) trsup_top_inst (.clk_i(clk_i), .reset_i(reset_i), .aux_on_i(aux_on),
    .aux_off_i(aux_off), .ext_block_one_i(blk1), .ext_block_two_i(blk2),
    .breaker_position_source_i(pos), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .active_o(active_o), .ext_blocked_flag_o(ext_blocked_flag_o),
    .alarm_o(alarm_o), .not_possible_o(not_possible_o), .irq_o(irq_o));

  // Clock of 10 ns and a cycle ceiling that cuts a hang short.
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_pin(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  // One-cycle strobes; read data is taken in the following cycle only.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask : rd_chk

  task automatic pins(input logic c, input logic v, input logic w, input logic b1, input logic b2);
    @(posedge clk_i);
    bk_closed <= c;
    supply_ok <= v;
    wire_ok <= w;
    blk1 <= b1;
    blk2 <= b2;
    #1;
  endtask : pins

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      cyc(1);
      seen = seen | alarm_o;
    end
    chk_pin("alarm held low", 1'b0, seen);
  endtask : quiet

  task automatic wait_alarm(input logic exp, input int n);
    int i;
    i = 0;
    #1;
    while (i < n && alarm_o !== exp)
    begin
      cyc(1);
      i++;
    end
    chk_pin("alarm", exp, alarm_o);
  endtask : wait_alarm

  // Main sequence: registers, alarm paths, blocking, modes, disable.
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd_chk(CTRL_ADDR, 16'h0000, "control");
    rd_chk(DELAY_ADDR, 16'h0014, "delay");
    rd_chk(4'hF, 16'h0000, "unmapped");
    wr(DELAY_ADDR, 16'h0001);
    rd_chk(DELAY_ADDR, 16'h000A, "delay low");
    wr(DELAY_ADDR, 16'h07FF);
    rd_chk(DELAY_ADDR, 16'h03E8, "delay high");
    wr(DELAY_ADDR, 16'h000A);
    wr(IRQ_ENABLE_ADDR, 16'h000F);
    wr(CTRL_ADDR, 16'h0001);
    pins(1, 0, 1, 0, 0);
    chk_pin("not possible", 1'b1, not_possible_o);
    chk_pin("active", 1'b1, active_o);
    quiet(60);
    pins(1, 1, 1, 0, 0);
    wr(CTRL_ADDR, 16'h0021);
    rd_chk(STATE_ADDR, 16'h0031, "state");
    pins(1, 0, 1, 0, 0);
    quiet(35);
    wait_alarm(1'b1, 20);
    rd_chk(IRQ_STATUS_ADDR, 16'h0009, "irq rise");
    chk_pin("irq", 1'b1, irq_o);
    pins(1, 1, 1, 0, 0);
    wait_alarm(1'b0, 4);
    rd_chk(IRQ_STATUS_ADDR, 16'h000B, "irq fall");
    wr(IRQ_CLEAR_ADDR, 16'h000F);
    rd_chk(IRQ_STATUS_ADDR, 16'h0000, "irq cleared");
    chk_pin("irq", 1'b0, irq_o);
    pins(1, 1, 0, 0, 0);
    quiet(30);
    pins(1, 1, 1, 0, 0);
    quiet(4);
    pins(1, 1, 0, 0, 0);
    quiet(35);
    wait_alarm(1'b1, 20);
    pins(1, 1, 1, 0, 0);
    wait_alarm(1'b0, 4);
    wr(CTRL_ADDR, 16'h0029);
    pins(1, 1, 1, 1, 0);
    cyc(3);
    chk_pin("blocked", 1'b0, ext_blocked_flag_o);
    wr(CTRL_ADDR, 16'h002B);
    rd_chk(STATE_ADDR, 16'h0075, "state blocked");
    pins(1, 0, 1, 1, 0);
    quiet(60);
    pins(1, 0, 1, 0, 1);
    cyc(3);
    chk_pin("blocked", 1'b0, ext_blocked_flag_o);
    wr(CTRL_ADDR, 16'h003B);
    cyc(1);
    chk_pin("blocked", 1'b1, ext_blocked_flag_o);
    rd_chk(STATE_ADDR, 16'h0078, "state blk two");
    quiet(50);
    wr(CTRL_ADDR, 16'h0021);
    pins(0, 0, 1, 0, 0);
    quiet(60);
    wr(CTRL_ADDR, 16'h0025);
    wait_alarm(1'b1, 50);
    wr(CTRL_ADDR, 16'h002F);
    pins(0, 0, 1, 1, 0);
    wait_alarm(1'b0, 4);
    wr(CTRL_ADDR, 16'h0024);
    cyc(1);
    chk_pin("active", 1'b0, active_o);
    chk_pin("alarm", 1'b0, alarm_o);
    wr(IRQ_ENABLE_ADDR, 16'h0000);
    cyc(1);
    chk_pin("irq", 1'b0, irq_o);
    report_and_stop();
  end
endmodule : trsup_top_test

bind trsup_top trsup_asserts #(.TICKS(TICKS)) trsup_asserts_inst (.clk_i(clk_i), .reset_i(reset_i),
  .aux_on_i(aux_on_i), .aux_off_i(aux_off_i), .ext_block_one_i(ext_block_one_i),
  .ext_block_two_i(ext_block_two_i), .breaker_position_source_i(breaker_position_source_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .active_o(active_o), .ext_blocked_flag_o(ext_blocked_flag_o), .alarm_o(alarm_o),
  .not_possible_o(not_possible_o), .irq_o(irq_o));
`default_nettype wire
